//--- pkg/ars_consts.svh
// Register offsets, codes and fixed values of the rate-select link and host
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH
`define ARS_REG_MODE 8'h10
`define ARS_REG_WAKE 8'h11
`define ARS_REG_ACT 8'h12
`define ARS_REG_RANGE 8'h15
`define ARS_REG_FIFO 8'h16
`define ARS_REG_PWR 8'h1c
`define ARS_REG_TRIG 8'h29
`define ARS_PM_ULP 3'h3
`define ARS_PM_LP 3'h0
`define ARS_PM_PREC 3'h4
`define ARS_CODE_FAST 4'hf
`define ARS_MODE_STANDBY 8'h01
`define ARS_MODE_WAKE 8'h05
`define ARS_PTR_SET 8'h10
`define ARS_PTR_S2 8'h20
`define ARS_PTR_V1 8'h40
`define ARS_PTR_V2 8'h50
`define ARS_NIB_SET 4'h1
`define ARS_NIB_S2 4'h2
`define ARS_NIB_V1 4'h4
`define ARS_NIB_V2 4'h5
`define ARS_SEQ_S1 8'h03
`define ARS_SEQ_S3 8'h01
`define ARS_V1_ULP 8'h52
`define ARS_V1_LP 8'h72
`define ARS_V1_PREC 8'h32
`define ARS_V2_ULP 8'h01
`define ARS_V2_LP 8'h02
`define ARS_V2_PREC 8'h12
`define ARS_SEQ_LAST 4'hd
`define ARS_ACT_RSV_BIT 4
`define ARS_WB_CTRL 8'h00
`define ARS_WB_STAT 8'h04
`define ARS_WB_CFG 8'h08
`define ARS_CFG_RESET 16'h5d04
`endif

//--- pkg/ars_pkg.sv
// Types and rate lookup functions shared by both ends
`default_nettype none
`include "ars_consts.svh"
package ars_pkg;
  typedef enum logic [1:0] {ARS_IDLE, ARS_REQ, ARS_GAP} ars_hstate_t;

  // Wake output rate in Hz, zero where the code is unavailable
  function automatic logic [10:0] ars_wake_hz(input logic [2:0] pm, input logic [3:0] c);
    logic [10:0] r;
    r = 11'h000;
    if (pm == `ARS_PM_ULP) begin
      case (c)
        4'h6: r = 11'h019;
        4'h7: r = 11'h032;
        4'h8: r = 11'h064;
        4'h9: r = 11'h0be;
        4'ha: r = 11'h17c;
        4'hb: r = 11'h2ee;
        4'hc: r = 11'h44c;
        4'hf: r = 11'h514;
        default: r = 11'h000;
      endcase
    end else if (pm == `ARS_PM_LP) begin
      case (c)
        4'h5: r = 11'h00e;
        4'h6: r = 11'h01c;
        4'h7: r = 11'h036;
        4'h8: r = 11'h069;
        4'h9: r = 11'h0d2;
        4'ha: r = 11'h190;
        4'hb: r = 11'h258;
        4'hf: r = 11'h2ee;
        default: r = 11'h000;
      endcase
    end else if (pm == `ARS_PM_PREC) begin
      case (c)
        4'h5: r = 11'h00e;
        4'h6: r = 11'h01c;
        4'h7: r = 11'h037;
        4'h8: r = 11'h050;
        4'hf: r = 11'h064;
        default: r = 11'h000;
      endcase
    end
    return r;
  endfunction

  // Activity-detect rate in tenths of Hz, zero where unavailable
  function automatic logic [13:0] ars_act_dhz(input logic [2:0] pm, input logic [3:0] c);
    logic [13:0] r;
    r = 14'h0000;
    if (pm == `ARS_PM_ULP) begin
      case (c)
        4'h0, 4'h4: r = 14'h003c;
        4'h1: r = 14'h0004;
        4'h2: r = 14'h0008;
        4'h3: r = 14'h000f;
        4'h5: r = 14'h0082;
        4'h6: r = 14'h00fa;
        4'h7: r = 14'h01f4;
        4'h8: r = 14'h03e8;
        4'h9: r = 14'h076c;
        4'ha: r = 14'h0ed8;
        4'hb: r = 14'h1d4c;
        4'hf: r = 14'h32c8;
        default: r = 14'h0000;
      endcase
    end else if (pm == `ARS_PM_LP) begin
      case (c)
        4'h0, 4'h4: r = 14'h0046;
        4'h1: r = 14'h0004;
        4'h2: r = 14'h0008;
        4'h3: r = 14'h000f;
        4'h5: r = 14'h008c;
        4'h6: r = 14'h0118;
        4'h7: r = 14'h021c;
        4'h8: r = 14'h041a;
        4'h9: r = 14'h0834;
        4'ha: r = 14'h0fa0;
        4'hb: r = 14'h1770;
        4'hf: r = 14'h1d4c;
        default: r = 14'h0000;
      endcase
    end else if (pm == `ARS_PM_PREC) begin
      case (c)
        4'h0, 4'h4: r = 14'h0046;
        4'h1: r = 14'h0002;
        4'h2: r = 14'h0004;
        4'h3: r = 14'h0009;
        4'h5: r = 14'h008c;
        4'h6: r = 14'h0118;
        4'h7: r = 14'h0226;
        4'h8: r = 14'h0320;
        4'hf: r = 14'h03e8;
        default: r = 14'h0000;
      endcase
    end
    return r;
  endfunction
endpackage
`default_nettype wire

//--- pkg/ars_link_if.sv
// Register access link between the host controller and the sensor registers
`timescale 1ns/1ps
`default_nettype none
interface ars_link_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport dev(input req, input we, input addr, input wdata, output ack, output rdata);
  modport host(output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

//--- logic/ars_dev.sv
// Sensor-side rate selection registers with indirect fastest-rate unlock
`timescale 1ns/1ps
`default_nettype none
`include "ars_consts.svh"
module ars_dev
  import ars_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  ars_link_if.dev link,
  output logic [2:0] mode_select_field,
  output logic [10:0] wake_odr_hz,
  output logic [13:0] activity_rate_dhz,
  output logic [2:0] standby_clock_rate,
  output logic [7:0] trigger_count,
  output logic fast_wake_armed,
  output logic [7:0] fast_value1,
  output logic [7:0] fast_value2
);
  logic [7:0] mode_ff, nxt_mode;
  logic [3:0] code_ff, nxt_code;
  logic [7:0] act_ff, nxt_act;
  logic [7:0] pwr_ff, nxt_pwr;
  logic [7:0] trig_ff, nxt_trig;
  logic [3:0] ptr_ff, nxt_ptr;
  logic [3:0] step_ff, nxt_step;
  logic [7:0] v1_ff, nxt_v1;
  logic [7:0] v2_ff, nxt_v2;
  logic fast_ff, nxt_fast;
  logic ack_ff, nxt_ack;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [10:0] odr_ff, nxt_odr;
  logic [13:0] adhz_ff, nxt_adhz;
  logic acc;
  logic wr;

  assign acc = link.req & ~ack_ff;
  assign wr = acc & link.we;

  // Register writes, pointer handling and rate decode
  always_comb begin
    nxt_mode = mode_ff;
    nxt_code = code_ff;
    nxt_act = act_ff;
    nxt_pwr = pwr_ff;
    nxt_trig = trig_ff;
    nxt_ptr = ptr_ff;
    nxt_step = step_ff;
    nxt_v1 = v1_ff;
    nxt_v2 = v2_ff;
    nxt_fast = fast_ff;
    nxt_ack = acc;
    nxt_rdata = rdata_ff;
    if (wr) begin
      case (link.addr)
        `ARS_REG_MODE: nxt_mode = link.wdata;
        `ARS_REG_WAKE: begin
          if (link.wdata[7:4] != 4'h0) begin
            nxt_ptr = link.wdata[7:4];
          end else begin
            nxt_code = link.wdata[3:0];
            nxt_ptr = 4'h0;
            nxt_fast = (link.wdata[3:0] == `ARS_CODE_FAST) && (step_ff == 4'hf);
            nxt_step = 4'h0;
          end
        end
        `ARS_REG_ACT: nxt_act = link.wdata & ~(8'h01 << `ARS_ACT_RSV_BIT);
        `ARS_REG_PWR: nxt_pwr = link.wdata;
        `ARS_REG_TRIG: begin
          case (ptr_ff)
            4'h0: nxt_trig = link.wdata;
            `ARS_NIB_SET: nxt_step[0] = (link.wdata == `ARS_SEQ_S1);
            `ARS_NIB_S2: nxt_step[1] = step_ff[0] && (link.wdata == `ARS_SEQ_S3);
            `ARS_NIB_V1: begin
              nxt_v1 = link.wdata;
              nxt_step[2] = step_ff[1];
            end
            `ARS_NIB_V2: begin
              nxt_v2 = link.wdata;
              nxt_step[3] = step_ff[2];
            end
            default: nxt_trig = trig_ff;
          endcase
        end
        default: nxt_mode = mode_ff;
      endcase
    end
    if (acc) begin
      case (link.addr)
        `ARS_REG_WAKE: nxt_rdata = {4'h0, code_ff};
        `ARS_REG_ACT: nxt_rdata = act_ff;
        `ARS_REG_PWR: nxt_rdata = pwr_ff;
        `ARS_REG_TRIG: nxt_rdata = trig_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
    // Code 0x0F yields a rate only after the unlock sequence
    if ((code_ff == `ARS_CODE_FAST) && !fast_ff) begin
      nxt_odr = 11'h000;
    end else begin
      nxt_odr = ars_wake_hz(pwr_ff[2:0], code_ff);
    end
    nxt_adhz = ars_act_dhz(pwr_ff[6:4], act_ff[3:0]);
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_ff <= 8'h00;
      code_ff <= 4'h0;
      act_ff <= 8'h00;
      pwr_ff <= 8'h00;
      trig_ff <= 8'h00;
      ptr_ff <= 4'h0;
      step_ff <= 4'h0;
      v1_ff <= 8'h00;
      v2_ff <= 8'h00;
      fast_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      odr_ff <= 11'h000;
      adhz_ff <= 14'h0000;
    end else begin
      mode_ff <= nxt_mode;
      code_ff <= nxt_code;
      act_ff <= nxt_act;
      pwr_ff <= nxt_pwr;
      trig_ff <= nxt_trig;
      ptr_ff <= nxt_ptr;
      step_ff <= nxt_step;
      v1_ff <= nxt_v1;
      v2_ff <= nxt_v2;
      fast_ff <= nxt_fast;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      odr_ff <= nxt_odr;
      adhz_ff <= nxt_adhz;
    end
  end

  assign link.ack = ack_ff;
  assign link.rdata = rdata_ff;
  assign mode_select_field = mode_ff[2:0];
  assign wake_odr_hz = odr_ff;
  assign activity_rate_dhz = adhz_ff;
  assign standby_clock_rate = act_ff[7:5];
  assign trigger_count = trig_ff;
  assign fast_wake_armed = fast_ff;
  assign fast_value1 = v1_ff;
  assign fast_value2 = v2_ff;
endmodule
`default_nettype wire

//--- logic/ars_host.sv
// Host controller: Wishbone command registers driving the sensor register link
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ars_consts.svh"
module ars_host
  import ars_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  ars_link_if.host link
);
  ars_hstate_t state_ff, nxt_state;
  logic [3:0] step_ff, nxt_step;
  logic seq_ff, nxt_seq;
  logic [1:0] psel_ff, nxt_psel;
  logic [7:0] addr_ff, nxt_addr;
  logic [7:0] data_ff, nxt_data;
  logic we_ff, nxt_we;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [7:0] pm_ff, nxt_pm;
  logic refused_ff, nxt_refused;
  logic [15:0] cfg_ff, nxt_cfg;
  logic [19:0] cmd_ff, nxt_cmd;
  logic wb_ack_ff, nxt_wb_ack;
  logic [31:0] wb_dat_ff, nxt_wb_dat;
  logic wb_acc;
  logic wb_wr;
  logic cmd_go;
  logic bad;
  logic [15:0] first;
  logic [15:0] next;
  logic [7:0] c_addr;
  logic [7:0] c_data;

  // Address and data of one step of the fastest-wake sequence
  function automatic logic [15:0] ars_step(input logic [3:0] i, input logic [1:0] s,
                                           input logic [15:0] cfg);
    logic [7:0] pm;
    logic [7:0] v1;
    logic [7:0] v2;
    logic [15:0] r;
    pm = {5'h00, `ARS_PM_ULP};
    v1 = `ARS_V1_ULP;
    v2 = `ARS_V2_ULP;
    if (s == 2'h1) begin
      pm = {5'h00, `ARS_PM_LP};
      v1 = `ARS_V1_LP;
      v2 = `ARS_V2_LP;
    end else if (s == 2'h2) begin
      pm = {5'h00, `ARS_PM_PREC};
      v1 = `ARS_V1_PREC;
      v2 = `ARS_V2_PREC;
    end
    case (i)
      4'h0: r = {`ARS_REG_MODE, `ARS_MODE_STANDBY};
      4'h1: r = {`ARS_REG_RANGE, cfg[7:0]};
      4'h2: r = {`ARS_REG_FIFO, cfg[15:8]};
      4'h3: r = {`ARS_REG_PWR, pm};
      4'h4: r = {`ARS_REG_WAKE, `ARS_PTR_SET};
      4'h5: r = {`ARS_REG_TRIG, `ARS_SEQ_S1};
      4'h6: r = {`ARS_REG_WAKE, `ARS_PTR_S2};
      4'h7: r = {`ARS_REG_TRIG, `ARS_SEQ_S3};
      4'h8: r = {`ARS_REG_WAKE, `ARS_PTR_V1};
      4'h9: r = {`ARS_REG_TRIG, v1};
      4'ha: r = {`ARS_REG_WAKE, `ARS_PTR_V2};
      4'hb: r = {`ARS_REG_TRIG, v2};
      4'hc: r = {`ARS_REG_WAKE, 4'h0, `ARS_CODE_FAST};
      default: r = {`ARS_REG_MODE, `ARS_MODE_WAKE};
    endcase
    return r;
  endfunction

  assign wb_acc = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  assign wb_wr = wb_acc & wb_we_i;
  assign cmd_go = wb_wr && (wb_adr_i == `ARS_WB_CTRL) && (wb_sel_i == 4'hf);
  assign c_addr = wb_dat_i[15:8];
  assign c_data = wb_dat_i[7:0];
  assign first = ars_step(4'h0, wb_dat_i[19:18], cfg_ff);
  assign next = ars_step(step_ff + 4'h1, psel_ff, cfg_ff);

  // Screen a single write against what the sensor may be given
  always_comb begin
    bad = 1'b0;
    if (wb_dat_i[16] && !wb_dat_i[17]) begin
      if (c_addr == `ARS_REG_WAKE) begin
        bad = (c_data[7:4] != 4'h0)
            || (c_data[3:0] == `ARS_CODE_FAST)
            || (ars_wake_hz(pm_ff[2:0], c_data[3:0]) == 11'h000);
      end else if (c_addr == `ARS_REG_ACT) begin
        bad = c_data[`ARS_ACT_RSV_BIT]
            || (c_data[3:0] == `ARS_CODE_FAST)
            || (ars_act_dhz(pm_ff[6:4], c_data[3:0]) == 14'h0000);
      end
    end
  end

  // Command engine, link sequencing and Wishbone register file
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_seq = seq_ff;
    nxt_psel = psel_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_we = we_ff;
    nxt_rdata = rdata_ff;
    nxt_pm = pm_ff;
    nxt_refused = refused_ff;
    nxt_cfg = cfg_ff;
    nxt_cmd = cmd_ff;
    nxt_wb_ack = wb_acc;
    nxt_wb_dat = wb_dat_ff;
    case (state_ff)
      ARS_IDLE: begin
        if (cmd_go) begin
          nxt_cmd = wb_dat_i[19:0];
          if (wb_dat_i[17]) begin
            nxt_seq = 1'b1;
            nxt_step = 4'h0;
            nxt_psel = wb_dat_i[19:18];
            nxt_addr = first[15:8];
            nxt_data = first[7:0];
            nxt_we = 1'b1;
            nxt_state = ARS_REQ;
          end else if (!bad) begin
            nxt_seq = 1'b0;
            nxt_addr = c_addr;
            nxt_data = c_data;
            nxt_we = wb_dat_i[16];
            nxt_state = ARS_REQ;
          end
        end
      end
      ARS_REQ: begin
        if (link.ack) begin
          if (!we_ff) begin
            nxt_rdata = link.rdata;
          end
          if (we_ff && (addr_ff == `ARS_REG_PWR)) begin
            nxt_pm = data_ff;
          end
          nxt_state = ARS_GAP;
        end
      end
      ARS_GAP: begin
        if (seq_ff && (step_ff != `ARS_SEQ_LAST)) begin
          nxt_step = step_ff + 4'h1;
          nxt_addr = next[15:8];
          nxt_data = next[7:0];
          nxt_state = ARS_REQ;
        end else begin
          nxt_seq = 1'b0;
          nxt_state = ARS_IDLE;
        end
      end
      default: nxt_state = ARS_IDLE;
    endcase
    // A refused or overlapping command raises the sticky flag; set beats clear
    if (wb_wr && (wb_adr_i == `ARS_WB_STAT) && wb_sel_i[1] && wb_dat_i[9]) begin
      nxt_refused = 1'b0;
    end
    if (cmd_go && ((state_ff != ARS_IDLE) || (bad && !wb_dat_i[17]))) begin
      nxt_refused = 1'b1;
    end
    if (wb_wr && (wb_adr_i == `ARS_WB_CFG)) begin
      if (wb_sel_i[0]) begin
        nxt_cfg[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        nxt_cfg[15:8] = wb_dat_i[15:8];
      end
    end
    if (wb_acc) begin
      case (wb_adr_i)
        `ARS_WB_CTRL: nxt_wb_dat = {12'h000, cmd_ff};
        `ARS_WB_STAT: nxt_wb_dat = {16'h0000, pm_ff[6:4], pm_ff[2:0], refused_ff,
                                    state_ff != ARS_IDLE, rdata_ff};
        `ARS_WB_CFG: nxt_wb_dat = {16'h0000, cfg_ff};
        default: nxt_wb_dat = 32'h0000_0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= ARS_IDLE;
      step_ff <= 4'h0;
      seq_ff <= 1'b0;
      psel_ff <= 2'h0;
      addr_ff <= 8'h00;
      data_ff <= 8'h00;
      we_ff <= 1'b0;
      rdata_ff <= 8'h00;
      pm_ff <= 8'h00;
      refused_ff <= 1'b0;
      cfg_ff <= `ARS_CFG_RESET;
      cmd_ff <= 20'h00000;
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      seq_ff <= nxt_seq;
      psel_ff <= nxt_psel;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      we_ff <= nxt_we;
      rdata_ff <= nxt_rdata;
      pm_ff <= nxt_pm;
      refused_ff <= nxt_refused;
      cfg_ff <= nxt_cfg;
      cmd_ff <= nxt_cmd;
      wb_ack_ff <= nxt_wb_ack;
      wb_dat_ff <= nxt_wb_dat;
    end
  end

  // Link and bus outputs
  assign link.req = (state_ff == ARS_REQ);
  assign link.we = we_ff;
  assign link.addr = addr_ff;
  assign link.wdata = data_ff;
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
endmodule
`default_nettype wire

//--- verif/ars_sva.sv
// Protocol and ordering checks on the register link between host and sensor
`timescale 1ns/1ps
`default_nettype none
`include "ars_consts.svh"
module ars_sva (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Handshake timing of each link transfer
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  a_answer_next_cycle: assert property (req && !ack |=> ack)
    else $error("link ack not one cycle after request");
  a_request_held: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("link request changed before ack");
  a_gap_after_ack: assert property (ack |=> !req)
    else $error("link request not dropped after ack");
  a_ack_needs_req: assert property (!req |=> !ack)
    else $error("link ack without request");
  // Content and order of writes issued by the host
  a_wake_upper_ptr: assert property (req && we && addr == `ARS_REG_WAKE
    && wdata[7:4] != 4'h0 |-> wdata inside {`ARS_PTR_SET, `ARS_PTR_S2, `ARS_PTR_V1, `ARS_PTR_V2})
    else $error("wake register upper bits set outside pointer step");
  a_act_bit_zero: assert property (req && we && addr == `ARS_REG_ACT |-> !wdata[4])
    else $error("activity register bit four written as one");
  a_fast_after_v2: assert property ($rose(req) && we && addr == `ARS_REG_WAKE
    && wdata == 8'h0f |-> $past(addr, 3) == `ARS_REG_TRIG && $past(wdata, 6) == `ARS_PTR_V2)
    else $error("fast wake code written outside the unlock sequence");
  a_wake_after_apply: assert property ($rose(req) && we && addr == `ARS_REG_WAKE
    && wdata == 8'h0f |-> ##3 req && addr == `ARS_REG_MODE && wdata == `ARS_MODE_WAKE)
    else $error("continuous wake not entered after apply");
  a_ptr_after_pwr: assert property ($rose(req) && we && addr == `ARS_REG_WAKE
    && wdata == `ARS_PTR_SET |-> $past(addr, 3) == `ARS_REG_PWR
    && $past(wdata, 12) == `ARS_MODE_STANDBY)
    else $error("settings pointer not preceded by standby and power mode");
  a_setup_two_order: assert property ($rose(req) && we && addr == `ARS_REG_WAKE
    && wdata == `ARS_PTR_S2 |-> $past(wdata, 3) == `ARS_SEQ_S1)
    else $error("second setup pointer not after first trigger count step");
  a_value_one_order: assert property ($rose(req) && we && addr == `ARS_REG_WAKE
    && wdata == `ARS_PTR_V1 |-> $past(wdata, 3) == `ARS_SEQ_S3)
    else $error("value one pointer not after third setup step");

  // Main scenarios reached
  c_fast_apply: cover property ($rose(req) && addr == `ARS_REG_WAKE && wdata == 8'h0f);
  c_link_read: cover property (ack && !we && rdata != 8'h00);
  c_act_write: cover property ($rose(req) && we && addr == `ARS_REG_ACT);
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Wishbone-driven bench for the host controller joined to the sensor registers
`timescale 1ns/1ps
`default_nettype none
`include "ars_consts.svh"
module testbench;
  logic ref_clk;
  logic resetn;
  logic cyc, stb, wbwe;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o, r;
  logic ack_o, armed;
  logic [2:0] mode, stby;
  logic [10:0] hz;
  logic [13:0] dhz;
  logic [7:0] trig, v1, v2;
  int bad_count, n_checks;

  ars_link_if link();
  ars_host ars_host_i(.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wbwe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack_o), .link(link));
  ars_dev ars_dev_i(.ref_clk(ref_clk), .resetn(resetn), .link(link), .mode_select_field(mode),
    .wake_odr_hz(hz), .activity_rate_dhz(dhz), .standby_clock_rate(stby),
    .trigger_count(trig), .fast_wake_armed(armed), .fast_value1(v1), .fast_value2(v2));
  ars_sva ars_sva_i(.ref_clk(ref_clk), .resetn(resetn), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // Compare one result and count it
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic Wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; wbwe <= w; adr <= a; dat <= d; sel <= s;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    r = dat_o;
    cyc <= 1'b0; stb <= 1'b0; wbwe <= 1'b0;
  endtask

  // Poll status until the link command is finished
  task wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, `ARS_WB_STAT, 32'h0, 4'hf);
      n++;
    end while (r[8] !== 1'b0 && n < 100);
    if (n >= 100) bad_count++;
  endtask

  // One single link access through the command register
  task cmd(input logic [7:0] a, input logic [7:0] d, input logic w);
    wb(1'b1, `ARS_WB_CTRL, {15'h0, w, a, d}, 4'hf);
    wait_idle();
  endtask

  // Program power modes and both rate registers, then check the decoded rates
  task rate(input logic [2:0] wpm, input logic [2:0] apm, input logic [3:0] wc,
            input logic [7:0] act, input logic [31:0] ehz, input logic [31:0] edhz);
    cmd(`ARS_REG_PWR, {1'b0, apm, 1'b0, wpm}, 1'b1);
    cmd(`ARS_REG_WAKE, {4'h0, wc}, 1'b1);
    cmd(`ARS_REG_ACT, act, 1'b1);
    chk(32'(hz), ehz);
    chk(32'(dhz), edhz);
    chk(32'(stby), 32'(act[7:5]));
    cmd(`ARS_REG_WAKE, 8'h00, 1'b0);
    chk({16'h0, r[15:0]}, {16'h0, apm, wpm, 2'h0, 4'h0, wc});
  endtask

  // A rejected single write sets the sticky flag, which then clears
  task refuse(input logic [7:0] a, input logic [7:0] d);
    cmd(a, d, 1'b1);
    chk(32'(r[9]), 32'h1);
    wb(1'b1, `ARS_WB_STAT, 32'h200, 4'hf);
    wb(1'b0, `ARS_WB_STAT, 32'h0, 4'hf);
    chk(32'(r[9]), 32'h0);
  endtask

  // Full fastest-wake unlock sequence for one power setting
  task fast(input logic [1:0] ps, input logic [2:0] pm, input logic [31:0] ehz,
            input logic [7:0] e1, input logic [7:0] e2);
    wb(1'b1, `ARS_WB_CTRL, {12'h0, ps, 2'h2, 16'h0}, 4'hf);
    wait_idle();
    chk({16'h0, r[15:10], 10'h0}, {16'h0, 3'h0, pm, 10'h0});
    chk(32'(armed), 32'h1);
    chk(32'(hz), ehz);
    chk(32'(mode), 32'h5);
    chk({16'h0, v1, v2}, {16'h0, e1, e2});
  endtask

  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [2:0] modes [6];
    modes = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    bad_count = 0; n_checks = 0;
    resetn = 1'b0; cyc = 1'b0; stb = 1'b0; wbwe = 1'b0;
    adr = 8'h00; sel = 4'h0; dat = 32'h0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    chk({hz, dhz, mode, stby, armed}, 32'h0);
    wb(1'b0, `ARS_WB_CFG, 32'h0, 4'hf);
    chk(r, 32'h5d04);
    wb(1'b1, `ARS_WB_CFG, 32'h0000aa55, 4'h1);
    wb(1'b0, `ARS_WB_CFG, 32'h0, 4'hf);
    chk(r, 32'h5d55);
    wb(1'b1, `ARS_WB_CFG, 32'h5d04, 4'hf);
    wb(1'b1, 8'h0c, 32'h1234, 4'hf);
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk(r, 32'h0);
    wb(1'b1, `ARS_WB_CTRL, 32'h11106, 4'h3);
    wb(1'b0, `ARS_WB_CTRL, 32'h0, 4'hf);
    chk(r, 32'h0);
    $display("test registers done");
    rate(3'h3, 3'h3, 4'h6, 8'he1, 32'h19, 32'h4);
    rate(3'h3, 3'h3, 4'hc, 8'h00, 32'h44c, 32'h3c);
    rate(3'h0, 3'h0, 4'hb, 8'h4b, 32'h258, 32'h1770);
    rate(3'h4, 3'h4, 4'h8, 8'h08, 32'h50, 32'h320);
    rate(3'h3, 3'h4, 4'h9, 8'h63, 32'hbe, 32'h9);
    rate(3'h4, 3'h4, 4'h5, 8'ha7, 32'he, 32'h226);
    $display("test rates done");
    refuse(`ARS_REG_WAKE, 8'h0f);
    refuse(`ARS_REG_WAKE, 8'h16);
    refuse(`ARS_REG_ACT, 8'h15);
    refuse(`ARS_REG_WAKE, 8'h09);
    refuse(`ARS_REG_ACT, 8'h09);
    chk(32'(hz), 32'he);
    $display("test refusals done");
    for (int i = 0; i < 6; i++) begin
      cmd(`ARS_REG_MODE, {5'h0, modes[i]}, 1'b1);
      chk(32'(mode), 32'(modes[i]));
    end
    // Plain trigger count write and read back while no pointer is set
    cmd(`ARS_REG_TRIG, 8'h2a, 1'b1);
    chk(32'(trig), 32'h2a);
    cmd(`ARS_REG_TRIG, 8'h00, 1'b0);
    chk(32'(r[7:0]), 32'h2a);
    $display("test modes done");
    fast(2'h0, `ARS_PM_ULP, 32'h514, `ARS_V1_ULP, `ARS_V2_ULP);
    fast(2'h1, `ARS_PM_LP, 32'h2ee, `ARS_V1_LP, `ARS_V2_LP);
    fast(2'h2, `ARS_PM_PREC, 32'h64, `ARS_V1_PREC, `ARS_V2_PREC);
    chk(32'(trig), 32'h2a);
    wb(1'b1, `ARS_WB_CTRL, 32'h20000, 4'hf);
    wb(1'b1, `ARS_WB_CTRL, 32'h12907, 4'hf);
    wait_idle();
    chk(32'(r[9]), 32'h1);
    $display("test fast wake done");
    print_verdict();
  end
endmodule
`default_nettype wire
